// ==== include/tcpm_pkg.sv ====
// Shared constants and types for the touch converter power-mode controller
package tcpm_pkg;

   // Register offsets (16-bit registers on the serial register port)
   localparam logic [7:0] ADDR_PWR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_AMB_CTRL0   = 8'h02;
   localparam logic [7:0] ADDR_THRESH      = 8'h04;
   localparam logic [7:0] ADDR_TOUCH       = 8'h08;
   localparam logic [7:0] ADDR_INT_STAT    = 8'h09;
   localparam logic [7:0] ADDR_MODE_STAT   = 8'h0A;
   localparam logic [7:0] ADDR_RESULT_BASE = 8'h10;
   localparam logic [7:0] ADDR_AMBIENT_BASE = 8'h18;

   // Field positions in power_and_conversion_control
   localparam int MODE_LSB       = 0;
   localparam int IVL_LSB        = 2;
   localparam int LAST_STAGE_LSB = 4;
   localparam int DECIM_LSB      = 8;
   localparam int INT_POL_BIT    = 11;
   // Field position in ambient_tracking_control_0
   localparam int TIMEOUT_LSB    = 8;
   // Field position in the interrupt status register
   localparam int NEW_DATA_BIT   = 8;

   // Operating-mode codes; bit 0 set means shutdown
   localparam logic [1:0] MODE_FULL = 2'h0;
   localparam logic [1:0] MODE_LOW  = 2'h2;
   localparam int         MODE_SHUT_BIT = 0;

   // Reset values
   localparam logic [15:0] PWR_CTRL_RST  = 16'h0070;
   localparam logic [15:0] AMB_CTRL0_RST = 16'h0400;
   localparam logic [15:0] THRESH_RST    = 16'h0100;

   // Timing
   localparam int CLK_HZ          = 20000000;
   localparam int FAST_PERIOD_MS  = 25;
   localparam int IDLE_STEP_MS    = 200;
   localparam int FAST_PERIOD_CYC = FAST_PERIOD_MS * (CLK_HZ / 1000);
   localparam int IDLE_STEP_CYC   = IDLE_STEP_MS * (CLK_HZ / 1000);
   localparam int TMR_W           = 25;

   // Baseline tracking filter strength
   localparam int AMB_SHIFT = 4;

   typedef enum logic [2:0] {
      ST_SHUT = 3'h1,
      ST_WAIT = 3'h2,
      ST_CONV = 3'h4
   } tcpm_state_type;

endpackage

// ==== logic/tcpm_thresh_cmp.sv ====
// Threshold compare and baseline tracking for one stage result
`timescale 1ns/10ps
module tcpm_thresh_cmp
   import tcpm_pkg::*;
(
   // Operands
   input  wire logic [15:0] result_in,
   input  wire logic [15:0] ambient_in,
   input  wire logic [15:0] thresh_in,
   // Outcome
   output logic             touch_out,
   output logic [15:0]      ambient_next_out
);

   logic signed [16:0] delta;
   logic        [15:0] magnitude;
   logic signed [16:0] step;

   always_comb begin
      delta     = $signed({1'b0, result_in}) - $signed({1'b0, ambient_in});
      magnitude = delta[16] ? 16'(-delta) : delta[15:0];
      // Either direction counts: input polarity depends on mux setup
      touch_out = (magnitude > thresh_in);
      // Slow first-order tracking keeps drift from looking like a touch
      step = delta >>> AMB_SHIFT;
      ambient_next_out = 16'($signed({1'b0, ambient_in}) + step);
   end

endmodule

// ==== logic/tcpm_timer.sv ====
// Down-counting interval timer for conversion scheduling
`timescale 1ns/10ps
module tcpm_timer
   import tcpm_pkg::*;
(
   // Clock and reset
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   // Control
   input  wire logic             load_in,
   input  wire logic [TMR_W-1:0] load_val_in,
   // Status
   output logic                  expired_out
);

   typedef struct packed {
      logic [TMR_W-1:0] count;
   } tcpm_tmr_type;

   tcpm_tmr_type s_reg;
   tcpm_tmr_type s_next;

   always_comb begin
      s_next = s_reg;
      if (load_in) begin
         s_next.count = load_val_in;
      end else if (s_reg.count != '0) begin
         s_next.count = s_reg.count - TMR_W'(1);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign expired_out = (s_reg.count == '0);

endmodule

// ==== logic/tcpm_top.sv ====
// Operating-mode control and conversion scheduling for the touch converter
//
// Operation
// - Mode field bits 1:0 at 0x000; 00 full power, 10 low power.
// - Mode codes 01 and 11 both mean complete shutdown.
// - Mode field resets to 00, so conversions start without host setup.
// - Full power keeps everything on and repeats sequences back to back.
// - Touched stages report data; untouched stages feed baseline tracking.
// - Low power idle: reduced state, one sequence per 200..800 ms interval.
// - Low power with touch: a new sequence every 25 ms.
// - After release, stay fast until the 0x002 timeout field runs out.
// - Change beyond threshold is an activation and updates status flags.
// - Interrupt output signals new data and sensor activations.
// - Every stage result is stored in readable registers.
// - Eight inputs share one 16-bit converter, polled in stage order.
// - Button states decided on chip and shown in status registers.
// - Interrupt pin is open drain with programmable active level.
`timescale 1ns/10ps
module tcpm_top
   import tcpm_pkg::*;
#(
   parameter int FAST_PERIOD_CYC_P = FAST_PERIOD_CYC,
   parameter int IDLE_STEP_CYC_P   = IDLE_STEP_CYC
)
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   // Register port from the serial interface engine
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   // Converter core
   output logic             conv_start_out,
   output logic      [2:0]  conv_stage_out,
   output logic      [1:0]  conv_decim_out,
   output logic             afe_power_out,
   input  wire logic        conv_done_in,
   input  wire logic [15:0] conv_result_in,
   // Open-drain interrupt pin
   output logic             int_pin_out,
   output logic             int_pin_oe_b_out
);

   // Block state other than the timer count in one record: registers, flags and sequencer
   // share one reset, so a host never sees a half-initialised map
   typedef struct packed {
      tcpm_state_type   state;
      logic [15:0]      pwr_ctrl;
      logic [15:0]      amb_ctrl;
      logic [15:0]      thresh;
      logic [2:0]       stage;
      logic [7:0][15:0] result;
      logic [7:0][15:0] ambient;
      logic [7:0]       touch;
      logic [7:0]       seq_touch;
      logic [7:0]       act_flags;
      logic             new_data;
      logic             reduced;
      logic             start;
      logic             tmr_load;
      logic [TMR_W-1:0] tmr_val;
      logic [3:0]       timeout_cnt;
      logic [15:0]      rdata;
      logic             int_oe_b;
   } tcpm_core_type;

   tcpm_core_type s_reg;
   tcpm_core_type s_next;

   logic        tmr_expired;
   logic        cmp_touch;
   logic [15:0] cmp_ambient_next;

   // True when the address falls in an eight-entry bank
   function automatic logic in_bank(input logic [7:0] addr,
                                    input logic [7:0] base);
      in_bank = (addr[7:3] == base[7:3]);
   endfunction

   // Idle interval codes 0..3 select one to four idle steps
   function automatic logic [TMR_W-1:0] idle_cycles(input logic [1:0] code);
      logic [TMR_W-1:0] step;
      step = TMR_W'(IDLE_STEP_CYC_P);
      idle_cycles = step + step * TMR_W'(code);
   endfunction

   // Open-drain level: a release (1) lets the pull-up show high. With
   // polarity 0 the pin is pulled low while an interrupt is pending.
   function automatic logic pin_release(input logic act,
                                        input logic pol);
      if (pol) begin
         pin_release = act;
      end else begin
         pin_release = !act;
      end
   endfunction

   // Timer loads one cycle after the sequence end; the wait state
   // ignores the stale expired flag during that cycle
   tcpm_timer tcpm_timer_inst (
      .mclk_in     (mclk_in),
      .rst_b_in    (rst_b_in),
      .load_in     (s_reg.tmr_load),
      .load_val_in (s_reg.tmr_val),
      .expired_out (tmr_expired)
   );

   // Compare works on the stage in flight; its baseline feeds back
   tcpm_thresh_cmp tcpm_thresh_cmp_inst (
      .result_in        (conv_result_in),
      .ambient_in       (s_reg.ambient[s_reg.stage]),
      .thresh_in        (s_reg.thresh),
      .touch_out        (cmp_touch),
      .ambient_next_out (cmp_ambient_next)
   );

   always_comb begin
      logic [1:0] mode;
      logic       shut;
      logic       low;
      logic [2:0] last;
      logic [7:0] touch_v;
      logic       int_act;
      logic       level;
      mode    = s_reg.pwr_ctrl[MODE_LSB +: 2];
      shut    = mode[MODE_SHUT_BIT];
      low     = (mode == MODE_LOW);
      last    = s_reg.pwr_ctrl[LAST_STAGE_LSB +: 3];
      touch_v = s_reg.seq_touch;
      int_act = 1'b0;
      level   = 1'b1;

      s_next          = s_reg;
      s_next.start    = 1'b0;
      s_next.tmr_load = 1'b0;

      // Register writes; status and results are read-only. Allowed in
      // shutdown too so the host can pick another mode.
      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_PWR_CTRL: begin
               s_next.pwr_ctrl = reg_wdata_in;
            end
            ADDR_AMB_CTRL0: begin
               s_next.amb_ctrl = reg_wdata_in;
            end
            ADDR_THRESH: begin
               s_next.thresh = reg_wdata_in;
            end
            default: begin
               // Read-only and unmapped addresses ignore writes
            end
         endcase
      end

      // Register reads; data stands until the next read
      if (reg_rd_in) begin
         case (reg_addr_in)
            ADDR_PWR_CTRL: begin
               s_next.rdata = s_reg.pwr_ctrl;
            end
            ADDR_AMB_CTRL0: begin
               s_next.rdata = s_reg.amb_ctrl;
            end
            ADDR_THRESH: begin
               s_next.rdata = s_reg.thresh;
            end
            ADDR_TOUCH: begin
               s_next.rdata = {8'h00, s_reg.touch};
            end
            ADDR_INT_STAT: begin
               s_next.rdata = {7'h00, s_reg.new_data, s_reg.act_flags};
               // Cleared here; a set later in this cycle still wins
               s_next.act_flags = '0;
               s_next.new_data  = 1'b0;
            end
            ADDR_MODE_STAT: begin
               s_next.rdata = {8'h00, s_reg.timeout_cnt, s_reg.reduced,
                               s_reg.state};
            end
            default: begin
               if (in_bank(reg_addr_in, ADDR_RESULT_BASE)) begin
                  s_next.rdata = s_reg.result[reg_addr_in[2:0]];
               end else if (in_bank(reg_addr_in, ADDR_AMBIENT_BASE)) begin
                  s_next.rdata = s_reg.ambient[reg_addr_in[2:0]];
               end else begin
                  // Unmapped space reads as zero
                  s_next.rdata = 16'h0000;
               end
            end
         endcase
      end

      unique case (s_reg.state)
         ST_SHUT: begin
            s_next.reduced = 1'b0;
            if (!shut) begin
               s_next.state     = ST_CONV;
               s_next.stage     = 3'h0;
               s_next.seq_touch = '0;
               s_next.start     = 1'b1;
            end
         end
         ST_WAIT: begin
            if (shut) begin
               s_next.state = ST_SHUT;
            end else if (!low || (tmr_expired && !s_reg.tmr_load)) begin
               // Wake for the next sequence; leaving low power skips wait
               s_next.state   = ST_CONV;
               s_next.stage   = 3'h0;
               s_next.start   = 1'b1;
               s_next.reduced = 1'b0;
            end
         end
         ST_CONV: begin
            if (shut) begin
               // A conversion in flight is abandoned, its result dropped
               s_next.state = ST_SHUT;
            end else if (conv_done_in) begin
               // Results land per stage; the last stage publishes touches
               s_next.result[s_reg.stage] = conv_result_in;
               if (cmp_touch) begin
                  s_next.seq_touch[s_reg.stage] = 1'b1;
                  touch_v[s_reg.stage] = 1'b1;
               end else begin
                  s_next.ambient[s_reg.stage] = cmp_ambient_next;
               end
               if (s_reg.stage == last) begin
                  s_next.touch     = touch_v;
                  s_next.act_flags = s_next.act_flags
                                   | (touch_v & ~s_reg.touch);
                  s_next.new_data  = 1'b1;
                  s_next.seq_touch = '0;
                  if (low) begin
                     s_next.state    = ST_WAIT;
                     s_next.tmr_load = 1'b1;
                     // Timeout counts whole fast sequences after release
                     if (|touch_v) begin
                        s_next.timeout_cnt =
                           s_reg.amb_ctrl[TIMEOUT_LSB +: 4];
                     end else if (s_reg.timeout_cnt != 4'h0) begin
                        s_next.timeout_cnt =
                           s_reg.timeout_cnt - 4'h1;
                     end
                     if ((|touch_v) || (s_reg.timeout_cnt > 4'h1)) begin
                        s_next.tmr_val = TMR_W'(FAST_PERIOD_CYC_P);
                        s_next.reduced = 1'b0;
                     end else begin
                        s_next.tmr_val =
                           idle_cycles(s_reg.pwr_ctrl[IVL_LSB +: 2]);
                        s_next.reduced = 1'b1;
                     end
                  end else begin
                     // Full power restarts at once: rate set by sequence
                     s_next.stage       = 3'h0;
                     s_next.start       = 1'b1;
                     s_next.timeout_cnt = 4'h0;
                  end
               end else begin
                  s_next.stage = s_reg.stage + 3'h1;
                  s_next.start = 1'b1;
               end
            end
         end
      endcase

      // Pin released when its level should be high; pull-up does the rest
      int_act = (|s_next.act_flags) | s_next.new_data;
      level   = pin_release(int_act, s_reg.pwr_ctrl[INT_POL_BIT]);
      s_next.int_oe_b = level;
   end

   // Synchronous reset; the mode field comes back as full power
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in) begin
         s_reg          <= '0;
         s_reg.state    <= ST_SHUT;
         s_reg.pwr_ctrl <= PWR_CTRL_RST;
         s_reg.amb_ctrl <= AMB_CTRL0_RST;
         s_reg.thresh   <= THRESH_RST;
         s_reg.int_oe_b <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Every output except int_pin_out, tied low, comes from the state record
   assign reg_rdata_out    = s_reg.rdata;
   assign conv_start_out   = s_reg.start;
   assign conv_stage_out   = s_reg.stage;
   assign conv_decim_out   = s_reg.pwr_ctrl[DECIM_LSB +: 2];
   // Analog side stays on except in shutdown or the idle wait
   assign afe_power_out    = (s_reg.state != ST_SHUT) && !s_reg.reduced;
   assign int_pin_out      = 1'b0;
   assign int_pin_oe_b_out = s_reg.int_oe_b;

endmodule

// ==== testbench/tcpm_conv_model.sv ====
// Converter core stand-in: answers each start after a set latency
`timescale 1ns/10ps
module tcpm_conv_model (
   // Clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_b_in,
   // Requests and bench stimulus
   input  wire logic       start_in,
   input  wire logic [2:0] stage_in,
   input  wire logic [7:0] touch_in,
   input  wire logic [3:0] lat_in,
   // Answer
   output logic            done_out   = 1'b0,
   output logic [15:0]     result_out = 16'h5A5A
);
   logic [3:0] cnt_reg   = 4'h0;
   logic [2:0] stage_reg = 3'h0;
   always @(posedge mclk_in) begin
      done_out <= 1'b0;
      // Result is only valid with done, so keep it moving otherwise
      result_out <= ~result_out;
      if (!rst_b_in)
         cnt_reg <= 4'h0;
      else if (start_in) begin
         cnt_reg <= lat_in;
         stage_reg <= stage_in;
      end else if (cnt_reg == 4'h1) begin
         cnt_reg <= 4'h0;
         done_out <= 1'b1;
         result_out <= touch_in[stage_reg] ? 16'h4000 : 16'h0100;
      end else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
endmodule

// ==== testbench/tcpm_properties.sv ====
// Port-level checks for the touch converter mode controller
`timescale 1ns/10ps
module tcpm_properties
   import tcpm_pkg::*;
#(
   parameter int FAST_PERIOD_CYC_P = 20,
   parameter int IDLE_STEP_CYC_P   = 50
)
(
   // Clock and reset
   input wire logic        mclk_in,
   input wire logic        rst_b_in,
   // Register port
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   // Converter and interrupt pin
   input wire logic        conv_start_out,
   input wire logic [2:0]  conv_stage_out,
   input wire logic [1:0]  conv_decim_out,
   input wire logic        afe_power_out,
   input wire logic        conv_done_in,
   input wire logic [15:0] conv_result_in,
   input wire logic        int_pin_out,
   input wire logic        int_pin_oe_b_out
);
   logic       ctrl_wr;
   logic [1:0] mode_reg;
   assign ctrl_wr = reg_wr_in && (reg_addr_in == ADDR_PWR_CTRL);
   // Shadow of the mode field, tracked from the writes alone
   always_ff @(posedge mclk_in) begin
      if (!rst_b_in)
         mode_reg <= MODE_FULL;
      else if (ctrl_wr)
         mode_reg <= reg_wdata_in[1:0];
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_shut_held;
      mode_reg[MODE_SHUT_BIT] [*4];
   endsequence
   sequence s_ctrl_write;
      ctrl_wr ##1 !ctrl_wr;
   endsequence
   a_reset_starts_full: assert property ($rose(rst_b_in) |=>
      conv_start_out && conv_stage_out == 3'h0 && afe_power_out)
      else $error("no stage 0 start after reset release");
   a_shut_quiet: assert property (s_shut_held |->
      !conv_start_out && !afe_power_out)
      else $error("activity during shutdown");
   a_done_restarts: assert property (mode_reg == MODE_FULL &&
      $stable(mode_reg) && conv_done_in |=> conv_start_out &&
      (conv_stage_out == $past(conv_stage_out) + 3'h1 ||
      conv_stage_out == 3'h0))
      else $error("full power did not start next stage");
   a_decim_follows: assert property (s_ctrl_write |=>
      conv_decim_out == $past(reg_wdata_in[9:8], 2))
      else $error("decimation output not updated");
   a_start_one_cycle: assert property (conv_start_out |=>
      !conv_start_out)
      else $error("start longer than one cycle");
   a_start_powered: assert property (conv_start_out |-> afe_power_out)
      else $error("start with analog unpowered");
   a_rdata_holds: assert property (!reg_rd_in |=>
      $stable(reg_rdata_out))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (reg_rd_in &&
      reg_addr_in >= 8'h20 |=> reg_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   a_pin_open_drain: assert property (int_pin_out == 1'b0)
      else $error("interrupt pin driven high");
endmodule
bind tcpm_top tcpm_properties #(
   .FAST_PERIOD_CYC_P(FAST_PERIOD_CYC_P),
   .IDLE_STEP_CYC_P(IDLE_STEP_CYC_P)
) tcpm_properties_inst (.*);

// ==== testbench/tcpm_top_tb.sv ====
// Self-checking bench for the touch converter mode controller
`timescale 1ns/10ps
module tcpm_top_tb;
   import tcpm_pkg::*;
   localparam int FAST = 20;
   localparam int STEP = 50;
   logic        mclk_in      = 1'b0;
   logic        rst_b_in     = 1'b0;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic [7:0]  reg_addr_in  = 8'h00;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic [15:0] reg_rdata_out;
   logic        conv_start_out;
   logic [2:0]  conv_stage_out;
   logic [1:0]  conv_decim_out;
   logic        afe_power_out;
   logic        conv_done_in;
   logic [15:0] conv_result_in;
   logic        int_pin_out;
   logic        int_pin_oe_b_out;
   logic [7:0]  touch = 8'h00;
   logic [3:0]  lat   = 4'h2;
   int          fails = 0;
   int          checks_done = 0;
   int          gap;
   logic        afe_mid;
   always #25 mclk_in = ~mclk_in;
   tcpm_top #(.FAST_PERIOD_CYC_P(FAST), .IDLE_STEP_CYC_P(STEP))
      tcpm_top_inst (.*);
   tcpm_conv_model tcpm_conv_model_inst (.mclk_in(mclk_in),
      .rst_b_in(rst_b_in), .start_in(conv_start_out),
      .stage_in(conv_stage_out), .touch_in(touch), .lat_in(lat),
      .done_out(conv_done_in), .result_out(conv_result_in));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] exp);
      @(posedge mclk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      @(negedge mclk_in);
      check(reg_rdata_out & m, exp);
   endtask
   // Cycles from the last-stage done to the next start
   task automatic seq_gap();
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (!(conv_done_in === 1'b1 && conv_stage_out === 3'h7)
                 && n < 4000);
      if (n >= 4000)
         fails++;
      gap = 0;
      afe_mid = 1'bx;
      do begin
         @(posedge mclk_in);
         gap++;
         if (gap == 5)
            afe_mid = afe_power_out;
      end while (conv_start_out !== 1'b1 && gap < 4000);
   endtask
   task automatic gap_is(input int t);
      check(16'((gap >= t + 1 && gap <= t + 4) ? t + 2 : gap), 16'(t + 2));
   endtask
   task automatic t_reset();
      rdchk(ADDR_PWR_CTRL, 16'hFFFF, PWR_CTRL_RST);
      rdchk(ADDR_AMB_CTRL0, 16'hFFFF, AMB_CTRL0_RST);
      rdchk(8'h30, 16'hFFFF, 16'h0000);
      rdchk(ADDR_THRESH, 16'hFFFF, THRESH_RST);
      wr(ADDR_THRESH, 16'h0180);
      rdchk(ADDR_THRESH, 16'hFFFF, 16'h0180);
      wr(ADDR_THRESH, THRESH_RST);
   endtask
   task automatic t_full();
      seq_gap();
      check(16'(gap), 16'h0001);
      check({15'h0, afe_power_out}, 16'h0001);
      rdchk(ADDR_RESULT_BASE + 8'h07, 16'hFFFF, 16'h0100);
      rdchk(ADDR_INT_STAT, 16'h0100, 16'h0100);
      seq_gap();
      repeat (3) @(posedge mclk_in);
      check({15'h0, int_pin_oe_b_out}, 16'h0000);
      wr(ADDR_PWR_CTRL, 16'h0170);
      repeat (3) @(posedge mclk_in);
      check({14'h0, conv_decim_out}, 16'h0001);
      wr(ADDR_PWR_CTRL, 16'h0070);
   endtask
   task automatic t_touch();
      touch <= 8'h84;
      repeat (2) seq_gap();
      rdchk(ADDR_TOUCH, 16'h00FF, 16'h0084);
      rdchk(ADDR_INT_STAT, 16'h00FF, 16'h0084);
      rdchk(ADDR_INT_STAT, 16'h00FF, 16'h0000);
      rdchk(ADDR_RESULT_BASE + 8'h02, 16'hFFFF, 16'h4000);
      wr(ADDR_PWR_CTRL, 16'h0870);
      seq_gap();
      repeat (3) @(posedge mclk_in);
      check({15'h0, int_pin_oe_b_out}, 16'h0001);
      wr(ADDR_PWR_CTRL, 16'h0070);
      touch <= 8'h00;
   endtask
   task automatic t_shut(input logic [1:0] m);
      int n;
      n = 0;
      lat <= 4'h9;
      wr(ADDR_PWR_CTRL, {14'h001C, m});
      repeat (5) @(posedge mclk_in);
      repeat (100) begin
         @(posedge mclk_in);
         n += int'(conv_start_out === 1'b1);
      end
      check(16'(n), 16'h0000);
      check({15'h0, afe_power_out}, 16'h0000);
      rdchk(ADDR_PWR_CTRL, 16'hFFFF, {14'h001C, m});
      rdchk(ADDR_MODE_STAT, 16'h0007, 16'h0001);
      wr(ADDR_PWR_CTRL, 16'h0070);
      n = 0;
      while (conv_start_out !== 1'b1 && n < 50) begin
         @(posedge mclk_in);
         n++;
      end
      check({15'h0, conv_start_out}, 16'h0001);
      check({13'h0, conv_stage_out}, 16'h0000);
      lat <= 4'h2;
   endtask
   task automatic t_low();
      wr(ADDR_AMB_CTRL0, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_PWR_CTRL, 16'h0072 | 16'(k << 2));
         repeat (2) seq_gap();
         gap_is((k + 1) * STEP);
         check({15'h0, afe_mid}, 16'h0000);
      end
      wr(ADDR_AMB_CTRL0, 16'h0200);
      wr(ADDR_PWR_CTRL, 16'h0072);
      touch <= 8'h01;
      repeat (2) seq_gap();
      gap_is(FAST);
      check({15'h0, afe_mid}, 16'h0001);
      touch <= 8'h00;
      seq_gap();
      gap_is(FAST);
      repeat (3) seq_gap();
      gap_is(STEP);
   endtask
   task automatic stop_test();
      if (fails == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #1000000;
      fails++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      t_reset();
      t_full();
      t_touch();
      t_shut(2'h1);
      t_shut(2'h3);
      t_low();
      stop_test();
   end
endmodule
